// >>> logic/usb_host_capability_registers.sv
// Functional notes
// [RULE1] Byte 0 of word 00h gives operational offset
// [RULE2] Bits 23:8 BCD version; 31:24 reserved
// [RULE3] Structural parameters word lives at offset 04h
// [RULE4] Bits 23:20 debug port, zero means none
// [RULE5] Debug port never exceeds reported port count
// [RULE6] Bit 16 reports port indicator support
// [RULE7] Bits 15:12 companion controller count
// [RULE8] Bits 11:8 ports per companion controller
// [RULE9] Bit 4 reports port power switches
// [RULE10] Bits 3:0 port count, 1h to Fh
// [RULE11] Writes ignored; reserved bits read zero
`timescale 1ns/1ps
`default_nettype none

module usb_host_capability_registers #(
  parameter logic [7:0]  CAP_SIZE        = capability_pkg::CAP_SIZE_RESET,
  parameter logic [15:0] VERSION         = capability_pkg::VERSION_RESET,
  parameter logic [3:0]  DEBUG_PORT      = capability_pkg::DEBUG_PORT_RESET,
  parameter logic        PORT_INDICATOR  = capability_pkg::PORT_INDICATOR_RESET,
  parameter logic [3:0]  COMPANION_COUNT = capability_pkg::COMPANION_COUNT_RESET,
  parameter logic [3:0]  PORTS_PER_COMP  = capability_pkg::PORTS_PER_COMP_RESET,
  parameter logic        ROUTING_RULE    = capability_pkg::ROUTING_RULE_RESET,
  parameter logic        POWER_SWITCH    = capability_pkg::POWER_SWITCH_RESET,
  parameter logic [3:0]  PORT_COUNT      = capability_pkg::PORT_COUNT_RESET
) (
  input  wire logic                                 clk,
  input  wire logic                                 rstn,
  input  wire logic                                 clk_en,
  input  wire logic                                 rd_en,
  input  wire logic [capability_pkg::ADDR_WIDTH-1:0] rd_addr,
  output logic      [capability_pkg::DATA_WIDTH-1:0] rd_data,
  output logic                                      rd_valid
);
  import capability_pkg::*;

  // ==========================================================
  // Field widths
  // Taken from the parameter types, so the masks follow any retyping.
  localparam int CAP_SIZE_WIDTH        = $bits(CAP_SIZE);
  localparam int VERSION_WIDTH         = $bits(VERSION);
  localparam int DEBUG_PORT_WIDTH      = $bits(DEBUG_PORT);
  localparam int COMPANION_COUNT_WIDTH = $bits(COMPANION_COUNT);
  localparam int PORTS_PER_COMP_WIDTH  = $bits(PORTS_PER_COMP);
  localparam int PORT_COUNT_WIDTH      = $bits(PORT_COUNT);

  // ==========================================================
  // Field sanitising
  // A zero port count is undefined for software, so it is raised to one.
  function automatic logic [3:0] legal_ports(input logic [3:0] n);
    legal_ports = (n < PORT_COUNT_MIN) ? PORT_COUNT_MIN : n; // [RULE10]
  endfunction

  // A debug port beyond the last port would point software at nothing.
  function automatic logic [3:0] legal_debug(input logic [3:0] d, input logic [3:0] n);
    legal_debug = (d > n) ? 4'h0 : d; // [RULE5]
  endfunction

  // ==========================================================
  // Readable bit masks
  // Every bit outside a listed field is cleared on the way out, so a
  // slip in word assembly can never show up in a reserved bit.
  function automatic logic [DATA_WIDTH-1:0] field_mask(input int lsb, input int width);
    logic [DATA_WIDTH-1:0] mask;
    mask = '0;
    for (int b = 0; b < DATA_WIDTH; b++) begin
      if ((b >= lsb) && (b < lsb + width)) begin
        mask[b] = 1'h1;
      end
    end
    field_mask = mask;
  endfunction

  localparam logic [DATA_WIDTH-1:0] CAP_READABLE =
    field_mask(CAP_SIZE_LSB, CAP_SIZE_WIDTH) |
    field_mask(VERSION_LSB, VERSION_WIDTH);

  localparam logic [DATA_WIDTH-1:0] STRUCT_READABLE =
    field_mask(DEBUG_PORT_LSB, DEBUG_PORT_WIDTH) |
    field_mask(PORT_INDICATOR_BIT, 1) |
    field_mask(COMPANION_COUNT_LSB, COMPANION_COUNT_WIDTH) |
    field_mask(PORTS_PER_COMP_LSB, PORTS_PER_COMP_WIDTH) |
    field_mask(ROUTING_RULE_BIT, 1) |
    field_mask(POWER_SWITCH_BIT, 1) |
    field_mask(PORT_COUNT_LSB, PORT_COUNT_WIDTH);

  // ==========================================================
  // Held capability fields, loaded only by reset
  // One small register per field; none of them has a write path.
  logic [7:0]  cap_size_r;
  logic [15:0] version_r;
  logic [3:0]  debug_port_r;
  logic        port_indicator_r;
  logic [3:0]  companion_count_r;
  logic [3:0]  ports_per_comp_r;
  logic        routing_rule_r;
  logic        power_switch_r;
  logic [3:0]  port_count_r;
  logic [31:0] rd_data_r;
  logic        rd_valid_r;

  wire  [3:0]  port_count_legal = legal_ports(PORT_COUNT);
  wire  [3:0]  debug_port_legal = legal_debug(DEBUG_PORT, port_count_legal);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cap_size_r <= CAP_SIZE; // [RULE1]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      version_r <= VERSION; // [RULE2]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      debug_port_r <= debug_port_legal; // [RULE4]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      port_indicator_r <= PORT_INDICATOR; // [RULE6]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      companion_count_r <= COMPANION_COUNT; // [RULE7]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ports_per_comp_r <= PORTS_PER_COMP; // [RULE8]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      routing_rule_r <= ROUTING_RULE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      power_switch_r <= POWER_SWITCH; // [RULE9]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      port_count_r <= port_count_legal; // [RULE10]
    end
  end

  // ==========================================================
  // Word assembly; unlisted bits stay zero
  logic [31:0] cap_word;
  logic [31:0] struct_word;

  always_comb begin
    cap_word = 32'h0000_0000; // [RULE11]
    cap_word[CAP_SIZE_LSB +: 8] = cap_size_r;  // [RULE1]
    cap_word[VERSION_LSB +: 16] = version_r;   // [RULE2]
  end

  always_comb begin
    struct_word = 32'h0000_0000; // [RULE11]
    struct_word[DEBUG_PORT_LSB +: 4]      = debug_port_r;      // [RULE4]
    struct_word[PORT_INDICATOR_BIT]       = port_indicator_r;  // [RULE6]
    struct_word[COMPANION_COUNT_LSB +: 4] = companion_count_r; // [RULE7]
    struct_word[PORTS_PER_COMP_LSB +: 4]  = ports_per_comp_r;  // [RULE8]
    struct_word[ROUTING_RULE_BIT]         = routing_rule_r;
    struct_word[POWER_SWITCH_BIT]         = power_switch_r;    // [RULE9]
    struct_word[PORT_COUNT_LSB +: 4]      = port_count_r;      // [RULE10]
  end

  // ==========================================================
  // Read decode
  // There is no write path at all, so nothing can alter these words.
  wire         hit_cap    = (rd_addr == CAP_SIZE_VERSION_OFFSET);
  wire         hit_struct = (rd_addr == STRUCT_PARAMS_OFFSET); // [RULE3]
  wire  [31:0] cap_word_out    = cap_word & CAP_READABLE;       // [RULE11]
  wire  [31:0] struct_word_out = struct_word & STRUCT_READABLE; // [RULE11]
  wire  [31:0] rd_mux          = hit_cap    ? cap_word_out    :
                                 hit_struct ? struct_word_out :
                                 UNMAPPED_READ_VALUE;

  // ==========================================================
  // Read port
  // A low clock enable holds both outputs, so a read answered just
  // before a stall is still on the bus when the stall ends.
  wire         take_read = clk_en && rd_en;
  logic [31:0] rd_data_nxt;
  logic        rd_valid_nxt;

  assign rd_data_nxt  = take_read ? rd_mux : rd_data_r;
  assign rd_valid_nxt = clk_en ? rd_en : rd_valid_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_data_r <= 32'h0000_0000;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_valid_r <= 1'h0;
    end else begin
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign rd_data  = rd_data_r;
  assign rd_valid = rd_valid_r;

endmodule // usb_host_capability_registers

`default_nettype wire

// >>> logic/capability_pkg.sv
package capability_pkg;

  // ==========================================================
  // Register map (byte offsets from the controller base)
  localparam logic [7:0] CAP_SIZE_VERSION_OFFSET = 8'h00;
  localparam logic [7:0] STRUCT_PARAMS_OFFSET    = 8'h04;
  localparam int         ADDR_WIDTH              = 8;
  localparam int         DATA_WIDTH              = 32;

  // ==========================================================
  // Field positions, capability word
  localparam int CAP_SIZE_LSB = 0;
  localparam int VERSION_LSB  = 8;

  // ==========================================================
  // Field positions, structural parameters word
  localparam int PORT_COUNT_LSB      = 0;
  localparam int POWER_SWITCH_BIT    = 4;
  localparam int ROUTING_RULE_BIT    = 7;
  localparam int PORTS_PER_COMP_LSB  = 8;
  localparam int COMPANION_COUNT_LSB = 12;
  localparam int PORT_INDICATOR_BIT  = 16;
  localparam int DEBUG_PORT_LSB      = 20;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  CAP_SIZE_RESET        = 8'h0c;
  localparam logic [15:0] VERSION_RESET         = 16'h9500;
  localparam logic [3:0]  DEBUG_PORT_RESET      = 4'h0;
  localparam logic        PORT_INDICATOR_RESET  = 1'b0;
  localparam logic [3:0]  COMPANION_COUNT_RESET = 4'h2;
  localparam logic [3:0]  PORTS_PER_COMP_RESET  = 4'h2;
  localparam logic        ROUTING_RULE_RESET    = 1'b0;
  localparam logic        POWER_SWITCH_RESET    = 1'b1;
  localparam logic [3:0]  PORT_COUNT_RESET      = 4'h4;
  localparam logic [3:0]  PORT_COUNT_MIN        = 4'h1;
  localparam logic [31:0] UNMAPPED_READ_VALUE   = 32'h0000_0000;

endpackage : capability_pkg

// >>> verification/capability_properties.sv
`timescale 1ns/1ps
`default_nettype none
module capability_checker (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        clk_en,
  input wire logic        rd_en,
  input wire logic [7:0]  rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic        rd_valid
);
  // ====================
  // Read timing and words
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire take = clk_en && rd_en;
  a_valid_follows: assert property (take |=> rd_valid) else $error("no valid");
  a_idle_quiet: assert property (clk_en && !rd_en |=> !rd_valid) else $error("stray valid");
  a_data_holds: assert property (!take |=> $stable(rd_data)) else $error("data moved");
  a_valid_frozen: assert property (!clk_en |=> $stable(rd_valid)) else $error("valid moved");
  a_cap_word: assert property (take && rd_addr == 8'h00 |=> rd_data == 32'h0095_000c)
    else $error("cap word");
  a_struct_word: assert property (take && rd_addr == 8'h04 |=> rd_data == 32'h0000_2214)
    else $error("struct word");
  a_unmapped_zero: assert property (take && rd_addr[7:3] != 5'h00 |=> rd_data == 32'h0000_0000)
    else $error("unmapped");
  a_debug_bound: assert property (take && rd_addr == 8'h04 |=>
    rd_data[23:20] <= rd_data[3:0] && rd_data[3:0] != 4'h0) else $error("debug port");
  c_cap: cover property (take && rd_addr == 8'h00);
  c_struct: cover property (take && rd_addr == 8'h04);
  c_back: cover property (take ##1 take);
endmodule // capability_checker
bind usb_host_capability_registers capability_checker chk (.clk(clk), .rstn(rstn),
  .clk_en(clk_en), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 0, rstn = 0, clk_en = 0, rd_en = 0, rd_valid, exp_valid = 0;
  logic [7:0]  rd_addr = 8'h00;
  logic [31:0] rd_data, exp_data = 0, r;
  int          miscompares = 0, n_compared = 0, seed = 6;
  usb_host_capability_registers uut (.clk(clk), .rstn(rstn), .clk_en(clk_en), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
  always #5 clk = ~clk;
  // ====================
  // Reference model and checks
  // Expected word from the documented reset values; all else reads zero
  function automatic int exp_word(input int addr);
    if (addr == 8'h00) return 32'h0095_000c;
    if (addr == 8'h04) return 32'h0000_2214;
    return 32'h0000_0000;
  endfunction
  always @(posedge clk) begin
    if (!rstn) begin
      exp_valid <= 0;
      exp_data <= 0;
    end else if (clk_en) begin
      exp_valid <= rd_en;
      if (rd_en) exp_data <= exp_word(rd_addr);
    end
  end
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t data %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_valid(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t valid %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    print_verdict;
  end
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1;
    // Random reads with stalls and one reset in mid-run
    for (int i = 0; i < 600; i++) begin
      @(negedge clk);
      chk_valid(rd_valid, exp_valid);
      chk_data(rd_data, exp_data);
      r = $random(seed);
      rstn = (i != 300);
      clk_en = r[3] | r[4];
      rd_en = r[5];
      rd_addr = r[2] ? r[15:8] : {5'h00, r[0], 2'h0};
    end
    @(negedge clk);
    chk_valid(rd_valid, exp_valid);
    chk_data(rd_data, exp_data);
    clk_en = 1;
    rd_en = 1;
    rd_addr = 8'h04;
    @(negedge clk);
    chk_valid(rd_valid, 1'h1);
    chk_data(rd_data & 32'h00f0_0000, 32'h0000_0000);
    chk_data(rd_data & 32'h0001_0000, 32'h0000_0000);
    chk_data(rd_data & 32'h0000_f000, 32'h0000_2000);
    chk_data(rd_data & 32'h0000_0f00, 32'h0000_0200);
    chk_data(rd_data & 32'h0000_0010, 32'h0000_0010);
    chk_data(rd_data & 32'h0000_000f, 32'h0000_0004);
    print_verdict;
  end
endmodule // tb
`default_nettype wire
